// ===== common/pll_seq_pkg.sv
/*
 * constants, register map, nvm defaults and mode type for the pll mode sequencer.
 * assumes a 250 MHz control clock and an apb register port with 32-bit data.
 */
// What this block does
// R1 - power-up init loads nvm defaults; register port stalls until init ends
// R2 - output clocks stay disabled while init runs
// R3 - hard reset pin or bit acts like power-up, reloading nvm defaults
// R4 - soft reset applies pending register settings without nvm reload
// R5 - after init the controller sits in exactly one of four modes
// R6 - free-run entered automatically once init completes
// R7 - lock acquisition starts whenever a valid input clock exists
// R8 - normal loop bandwidth register code spans 0.1 Hz to 4 kHz
// R9 - separate fast-lock bandwidth 100 Hz to 4 kHz, used only in acquisition
// R10 - fast-lock bandwidth during acquisition, normal bandwidth once locked
// R11 - lock state shown on lock-lost pin and status bit
// R12 - holdover entered when selected input fails and no other is valid
// R13 - up to 120 s of frequency history recorded while locked
// R14 - holdover frequency averages a programmable window after a programmable delay
// R15 - valid input during holdover leaves holdover and re-acquires lock
// R16 - register selects crystal or external reference; external disables crystal caps
// R17 - reference predivider allows external references above 54 MHz
// R18 - frequency adjust trims reference-derived frequency within plus or minus 200 ppm
// R19 - each step-up adds step word, each step-down subtracts; pins or registers
// R20 - steps apply to any set of output dividers at once or singly
// R21 - oscillator-step mode works only in free-run or locked mode
// R22 - input chosen manually or by automatic selection
// R23 - lock-lost stays asserted during pull-in after an input switch
// R24 - step requests during acquisition or holdover are ignored
// R25 - mode transitions evaluated synchronously, exactly one mode at a time
package pll_seq_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int INIT_NS = 2000;
    localparam int INIT_CYCLES = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int HIST_SECONDS = 120;
    localparam int FADJ_PPM = 200;
    localparam int FADJ_STEPS_PER_PPM = 100;
    localparam int FADJ_LIMIT = FADJ_PPM * FADJ_STEPS_PER_PPM;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_BW = 12'h004;
    localparam logic [11:0] OFS_REF = 12'h008;
    localparam logic [11:0] OFS_HOLD = 12'h00C;
    localparam logic [11:0] OFS_FSW = 12'h010;
    localparam logic [11:0] OFS_STEP = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_HOLDF = 12'h01C;
    localparam logic [11:0] OFS_DIV = 12'h020;
    localparam int CFG_WORDS = 4;
    localparam int CFG_CTRL = 0;
    localparam int CFG_BW = 1;
    localparam int CFG_REF = 2;
    localparam int CFG_HOLD = 3;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CTRL_HARD = 0;
    localparam int CTRL_SOFT = 1;
    localparam int CTRL_FAST = 2;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_SEL = 4;
    localparam int CTRL_EXTREF = 6;
    localparam int CTRL_STEP_EN = 7;
    localparam int BW_FAST = 8;
    localparam int REF_FADJ = 16;
    localparam int HOLD_DLY = 8;
    localparam int STEP_INC = 0;
    localparam int STEP_DEC = 1;
    localparam int STEP_MASK = 8;
    localparam int ST_LOL = 3;
    localparam int ST_SEL = 4;
    localparam int ST_VALID = 8;
    localparam logic [31:0] CTRL_PULSES = 32'h0000_0003;
    // bandwidth codes: 0 is 0.1 Hz, 8 is 100 Hz, 15 is 4 kHz
    localparam logic [3:0] BW_CODE_MAX = 4'hF;
    localparam logic [3:0] FAST_CODE_MIN = 4'h8;

    // ------------------------------------------------------------
    // nvm image
    // ------------------------------------------------------------
    localparam logic [31:0] NVM_CTRL = 32'h0000_000C;
    localparam logic [31:0] NVM_BW = 32'h0000_0C04;
    localparam logic [31:0] NVM_REF = 32'h0000_0001;
    localparam logic [31:0] NVM_HOLD = 32'h0000_0102;
    localparam logic [31:0] NVM_FSW = 32'h0000_0100;
    localparam logic [31:0] NVM_DIV = 32'h1000_0000;

    typedef enum logic [2:0] {
        MODE_INIT, MODE_FREE_RUN, MODE_ACQUIRE, MODE_LOCKED, MODE_HOLDOVER
    } mode_e;

endpackage

// ===== core/pll_mode_sequencer.sv
/*
 * pll mode sequencer: init, resets, mode machine, bandwidth, holdover averaging,
 * reference select and oscillator-step divider updates behind an apb slave.
 * assumes inputs synchronous to pclk; validity and lock come from the monitors.
 */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module pll_mode_sequencer import pll_seq_pkg::*; #(
    parameter int NUM_IN = 4,
    parameter int NUM_DIV = 4,
    parameter int FW = 32,
    parameter int HIST_DEPTH = 16
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host pins
    input wire logic hard_reset_pin_n,
    input wire logic step_up_pin,
    input wire logic step_down_pin,
    // monitors
    input wire logic [NUM_IN-1:0] input_valid,
    input wire logic phase_locked,
    input wire logic [FW-1:0] freq_sample,
    input wire logic freq_sample_valid,
    // loop control
    output logic clocks_enable,
    output logic lock_lost_indicator,
    output logic [2:0] pll_mode,
    output logic [3:0] loop_bw_code,
    output logic fastlock_active,
    output logic [$clog2(NUM_IN)-1:0] selected_input,
    output logic ref_external,
    output logic xtal_caps_enable,
    output logic [7:0] ref_prediv,
    output logic [15:0] freq_adjust,
    output logic [FW-1:0] holdover_freq,
    output logic [NUM_DIV*32-1:0] divider_freq
);
    localparam int SW = $clog2(NUM_IN);
    localparam int HW = $clog2(HIST_DEPTH);

    mode_e mode, next_mode;
    logic [15:0] init_cnt, next_init_cnt;
    logic [SW-1:0] sel, next_sel;
    logic [31:0] cfg_sh [CFG_WORDS];
    logic [31:0] next_cfg_sh [CFG_WORDS];
    logic [31:0] cfg_act [CFG_WORDS];
    logic [31:0] next_cfg_act [CFG_WORDS];
    logic [31:0] frequency_step_word, next_fsw;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic hard_req, next_hard_req;
    logic reg_inc, next_reg_inc, reg_dec, next_reg_dec;
    logic [NUM_DIV-1:0] step_mask, next_step_mask;
    logic up_prev, down_prev;
    logic hard_now, acc, step_ok, do_inc, do_dec, cand_valid;
    logic [FW-1:0] hist [HIST_DEPTH];
    logic [HW-1:0] wr_ptr, next_wr_ptr;
    logic [HW:0] fill, next_fill;
    logic [FW-1:0] next_hold_freq, avg;
    logic avg_ok;
    logic next_lol, next_clk_en, next_fast;
    logic [3:0] next_bw;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    assign hard_now = !hard_reset_pin_n || hard_req; // [R3]
    assign acc = psel && penable && pready;

    always_comb begin
        next_cfg_sh = cfg_sh;
        next_cfg_act = cfg_act;
        next_fsw = frequency_step_word;
        next_hard_req = 1'b0;
        next_reg_inc = 1'b0;
        next_reg_dec = 1'b0;
        next_step_mask = step_mask;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        // held off while init runs, so the master simply waits
        next_pready = psel && penable && !pready && mode != MODE_INIT; // [R1]
        if (next_pready) begin
            next_prdata = 32'h0000_0000;
            next_pslverr = 1'b0;
            if (paddr < OFS_FSW) begin
                next_prdata = cfg_sh[paddr[3:2]];
            end else if (paddr == OFS_FSW) begin
                next_prdata = frequency_step_word;
            end else if (paddr == OFS_STEP) begin
                next_prdata[STEP_MASK +: NUM_DIV] = step_mask;
            end else if (paddr == OFS_STATUS) begin
                next_prdata[2:0] = mode;
                next_prdata[ST_LOL] = lock_lost_indicator; // [R11]
                next_prdata[ST_SEL +: SW] = sel;
                next_prdata[ST_VALID +: NUM_IN] = input_valid;
            end else if (paddr == OFS_HOLDF) begin
                next_prdata = 32'(holdover_freq);
            end else if (paddr >= OFS_DIV && paddr < OFS_DIV + 12'(4 * NUM_DIV)) begin
                next_prdata = divider_freq[32 * int'(paddr[HW+1:2] - OFS_DIV[HW+1:2]) +: 32];
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (acc && pwrite) begin
            if (paddr < OFS_FSW) begin
                // pending until a soft reset; pulse bits are never stored
                next_cfg_sh[paddr[3:2]] = paddr == OFS_CTRL ? pwdata & ~CTRL_PULSES : pwdata; // [R4]
                if (paddr == OFS_CTRL) begin
                    next_hard_req = pwdata[CTRL_HARD]; // [R3]
                    if (pwdata[CTRL_SOFT]) begin
                        next_cfg_act = cfg_sh; // [R4]
                    end
                end
            end else if (paddr == OFS_FSW) begin
                next_fsw = pwdata;
            end else if (paddr == OFS_STEP) begin
                next_reg_inc = pwdata[STEP_INC]; // [R19]
                next_reg_dec = pwdata[STEP_DEC]; // [R19]
                next_step_mask = pwdata[STEP_MASK +: NUM_DIV]; // [R20]
            end
        end
        if (hard_now) begin
            next_cfg_sh = '{NVM_CTRL, NVM_BW, NVM_REF, NVM_HOLD}; // [R3]
            next_cfg_act = '{NVM_CTRL, NVM_BW, NVM_REF, NVM_HOLD}; // [R1]
            next_fsw = NVM_FSW;
            next_step_mask = '1;
            next_pready = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_sh <= '{NVM_CTRL, NVM_BW, NVM_REF, NVM_HOLD};
            cfg_act <= '{NVM_CTRL, NVM_BW, NVM_REF, NVM_HOLD};
            frequency_step_word <= NVM_FSW;
            hard_req <= 1'b0;
            reg_inc <= 1'b0;
            reg_dec <= 1'b0;
            step_mask <= '1;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            up_prev <= 1'b0;
            down_prev <= 1'b0;
        end else if (ce) begin
            cfg_sh <= next_cfg_sh;
            cfg_act <= next_cfg_act;
            frequency_step_word <= next_fsw;
            hard_req <= next_hard_req;
            reg_inc <= next_reg_inc;
            reg_dec <= next_reg_dec;
            step_mask <= next_step_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            up_prev <= step_up_pin;
            down_prev <= step_down_pin;
        end
    end

    // ------------------------------------------------------------
    // mode machine
    // ------------------------------------------------------------
    always_comb begin
        // non-revertive: keep the current input while it stays valid
        next_sel = sel; // [R22]
        if (!cfg_act[CFG_CTRL][CTRL_AUTO]) begin
            next_sel = cfg_act[CFG_CTRL][CTRL_SEL +: SW];
        end else if (!input_valid[sel]) begin
            for (int i = NUM_IN - 1; i >= 0; i--) begin
                if (input_valid[i]) begin
                    next_sel = SW'(i);
                end
            end
        end
        cand_valid = input_valid[next_sel];
        next_mode = mode;
        next_init_cnt = init_cnt;
        unique case (mode) // [R5]
            MODE_INIT: begin
                if (init_cnt != 16'h0000) begin
                    next_init_cnt = init_cnt - 16'h0001;
                end else begin
                    next_mode = MODE_FREE_RUN; // [R6]
                end
            end
            MODE_FREE_RUN: begin
                if (cand_valid) begin
                    next_mode = MODE_ACQUIRE; // [R7]
                end
            end
            MODE_ACQUIRE: begin
                if (!cand_valid) begin
                    next_mode = fill != '0 ? MODE_HOLDOVER : MODE_FREE_RUN;
                end else if (phase_locked && next_sel == sel) begin
                    next_mode = MODE_LOCKED;
                end
            end
            MODE_LOCKED: begin
                if (!cand_valid) begin
                    next_mode = MODE_HOLDOVER; // [R12]
                end else if (next_sel != sel || !phase_locked) begin
                    next_mode = MODE_ACQUIRE; // [R23]
                end
            end
            MODE_HOLDOVER: begin
                if (cand_valid) begin
                    next_mode = MODE_ACQUIRE; // [R15]
                end
            end
        endcase
        if (hard_now) begin
            next_mode = MODE_INIT; // [R3]
            next_init_cnt = 16'(INIT_CYCLES);
            next_sel = '0;
        end
        next_clk_en = next_mode != MODE_INIT; // [R2]
        next_lol = next_mode != MODE_LOCKED; // [R11]
        // fast code floored at 100 Hz; used only while acquiring
        next_fast = next_mode == MODE_ACQUIRE && cfg_act[CFG_CTRL][CTRL_FAST]; // [R9]
        next_bw = next_fast ? // [R10]
            (cfg_act[CFG_BW][BW_FAST +: 4] < FAST_CODE_MIN ? FAST_CODE_MIN : cfg_act[CFG_BW][BW_FAST +: 4]) :
            cfg_act[CFG_BW][3:0]; // [R8]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_INIT;
            init_cnt <= 16'(INIT_CYCLES);
            sel <= '0;
            clocks_enable <= 1'b0;
            lock_lost_indicator <= 1'b1;
            fastlock_active <= 1'b0;
            loop_bw_code <= BW_CODE_MAX;
            pll_mode <= 3'h0;
            selected_input <= '0;
            ref_external <= 1'b0;
            xtal_caps_enable <= 1'b1;
            ref_prediv <= 8'h00;
            freq_adjust <= 16'h0000;
        end else if (ce) begin
            mode <= next_mode; // [R25]
            init_cnt <= next_init_cnt;
            sel <= next_sel;
            clocks_enable <= next_clk_en;
            lock_lost_indicator <= next_lol;
            fastlock_active <= next_fast;
            loop_bw_code <= next_bw;
            pll_mode <= next_mode;
            selected_input <= next_sel;
            ref_external <= cfg_act[CFG_CTRL][CTRL_EXTREF]; // [R16]
            xtal_caps_enable <= !cfg_act[CFG_CTRL][CTRL_EXTREF]; // [R16]
            ref_prediv <= cfg_act[CFG_REF][7:0]; // [R17]
            // clamp keeps the trim inside the pull range of the reference
            if (int'($signed(cfg_act[CFG_REF][REF_FADJ +: 16])) > FADJ_LIMIT) begin
                freq_adjust <= 16'(FADJ_LIMIT); // [R18]
            end else if (int'($signed(cfg_act[CFG_REF][REF_FADJ +: 16])) < -FADJ_LIMIT) begin
                freq_adjust <= 16'(-FADJ_LIMIT); // [R18]
            end else begin
                freq_adjust <= cfg_act[CFG_REF][REF_FADJ +: 16];
            end
        end
    end

    // ------------------------------------------------------------
    // holdover history
    // ------------------------------------------------------------
    // one sample per HIST_SECONDS / HIST_DEPTH seconds, paced by the monitor
    always_comb begin
        logic [FW+HW:0] sum;
        int dly;
        int win;
        sum = '0;
        dly = int'(cfg_act[CFG_HOLD][HOLD_DLY +: 4]);
        win = 1 << cfg_act[CFG_HOLD][3:0];
        for (int k = 0; k < HIST_DEPTH; k++) begin
            if (k < win && k + dly < int'(fill)) begin
                sum = sum + hist[HW'(int'(wr_ptr) - 1 - dly - k)]; // [R14]
            end
        end
        avg_ok = win + dly <= int'(fill) && win <= HIST_DEPTH;
        avg = FW'(sum >> cfg_act[CFG_HOLD][3:0]); // [R14]
        next_wr_ptr = wr_ptr;
        next_fill = fill;
        if (mode == MODE_LOCKED && freq_sample_valid) begin
            next_wr_ptr = wr_ptr + 1'b1; // [R13]
            if (fill != (HW+1)'(HIST_DEPTH)) begin
                next_fill = fill + 1'b1;
            end
        end
        next_hold_freq = holdover_freq;
        if (next_mode == MODE_HOLDOVER && mode != MODE_HOLDOVER && avg_ok) begin
            next_hold_freq = avg; // [R14]
        end
        if (hard_now) begin
            next_wr_ptr = '0;
            next_fill = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            fill <= '0;
            holdover_freq <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            fill <= next_fill;
            holdover_freq <= next_hold_freq;
        end
    end

    // storage has no reset so it maps to plain ram
    always_ff @(posedge pclk) begin
        if (ce && mode == MODE_LOCKED && freq_sample_valid) begin
            hist[wr_ptr] <= freq_sample; // [R13]
        end
    end

    // ------------------------------------------------------------
    // oscillator-step dividers
    // ------------------------------------------------------------
    assign step_ok = cfg_act[CFG_CTRL][CTRL_STEP_EN] && (mode == MODE_FREE_RUN || mode == MODE_LOCKED); // [R21]
    assign do_inc = step_ok && (reg_inc || (step_up_pin && !up_prev)); // [R24]
    assign do_dec = step_ok && (reg_dec || (step_down_pin && !down_prev)); // [R24]

    for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
        logic [31:0] next_div;
        always_comb begin
            next_div = divider_freq[32*d +: 32];
            // simultaneous up and down cancel rather than pick a winner
            if (step_mask[d] && do_inc && !do_dec) begin
                next_div = divider_freq[32*d +: 32] + frequency_step_word; // [R19]
            end else if (step_mask[d] && do_dec && !do_inc) begin
                next_div = divider_freq[32*d +: 32] - frequency_step_word; // [R19]
            end
            if (hard_now) begin
                next_div = NVM_DIV;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                divider_freq[32*d +: 32] <= NVM_DIV;
            end else if (ce) begin
                divider_freq[32*d +: 32] <= next_div; // [R20]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_init_clocks_off: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R2]
        mode == MODE_INIT |-> !clocks_enable) else $error("clocks enabled during init");
    a_init_bus_stall: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R1]
        $past(mode) == MODE_INIT |-> !pready) else $error("bus answered during init");
    a_hard_reinit: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R3]
        !hard_reset_pin_n |=> mode == MODE_INIT && init_cnt == 16'(INIT_CYCLES))
        else $error("hard reset did not restart init");
    a_free_after_init: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R6]
        mode == MODE_INIT && init_cnt == 16'h0000 && !hard_now |=> mode == MODE_FREE_RUN)
        else $error("free-run not entered after init");
    a_acquire_start: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R7]
        mode == MODE_FREE_RUN && cand_valid && !hard_now |=> mode == MODE_ACQUIRE)
        else $error("acquisition not started");
    a_lol_tracks_mode: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R11]
        lock_lost_indicator == (mode != MODE_LOCKED)) else $error("lock-lost mismatch");
    a_normal_bw_locked: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R10]
        mode == MODE_LOCKED |-> !fastlock_active) else $error("fast bandwidth while locked");
    a_holdover_entry: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R12]
        mode == MODE_LOCKED && input_valid == '0 && !hard_now |=> mode == MODE_HOLDOVER)
        else $error("holdover not entered");
    a_step_blocked: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R24]
        (mode == MODE_ACQUIRE || mode == MODE_HOLDOVER) && !hard_now |=> $stable(divider_freq))
        else $error("divider stepped outside free-run or locked");
    a_caps_follow_ref: assert property (@(posedge pclk) disable iff (!presetn || !ce) // [R16]
        xtal_caps_enable != ref_external) else $error("crystal caps on with external ref");

endmodule // pll_mode_sequencer

// ===== verification/input_monitor_model.sv
/*
 * monitor stand-in: input validity, phase lock and frequency samples.
 * assumes the bench asks for valid inputs through want_valid.
 */
`timescale 1ns/1ps
module input_monitor_model #(
    parameter int LOCK_DLY = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request and monitor outputs
    input wire logic [3:0] want_valid,
    output logic [3:0] input_valid,
    output logic phase_locked,
    output logic [31:0] freq_sample,
    output logic freq_sample_valid
);
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            input_valid <= 4'h0;
        end else begin
            input_valid <= want_valid;
            cnt <= (want_valid == 4'h0) ? 0 : cnt + 1;
        end
    end
    // lock only after a pull-in delay, lost at once with the inputs
    assign phase_locked = (cnt > LOCK_DLY);
    // samples cycle 3,7,11,15 so any four average to 9
    assign freq_sample_valid = (cnt[1:0] == 2'h3);
    assign freq_sample = 32'h4000_0000 + 32'(cnt[3:0]);
endmodule // input_monitor_model

// ===== verification/pll_mode_sequencer_tb_top.sv
/*
 * bench for the pll mode sequencer: apb host, step pins, monitor model.
 * assumes package nvm defaults and a 250 MHz pclk.
 */
`timescale 1ns/1ps
module pll_mode_sequencer_tb_top import pll_seq_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, up;
    logic hard_reset_pin_n, step_up_pin, step_down_pin, phase_locked, freq_sample_valid;
    logic clocks_enable, lock_lost_indicator, fastlock_active, xtal_caps_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, freq_sample, holdover_freq, rd, frequency_step_word, d0, d1;
    logic [3:0] want_valid, input_valid, loop_bw_code;
    logic [2:0] pll_mode;
    logic [1:0] selected_input;
    logic [127:0] divider_freq;
    int num_errors = 0;
    int check_count = 0;
    pll_mode_sequencer uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hard_reset_pin_n, .step_up_pin, .step_down_pin, .input_valid,
        .phase_locked, .freq_sample, .freq_sample_valid, .clocks_enable, .lock_lost_indicator,
        .pll_mode, .loop_bw_code, .fastlock_active, .selected_input, .ref_external(),
        .xtal_caps_enable, .ref_prediv(), .freq_adjust(), .holdover_freq, .divider_freq);
    input_monitor_model mon (.pclk, .presetn, .want_valid, .input_valid, .phase_locked,
        .freq_sample, .freq_sample_valid);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] stepped(input logic [31:0] v, input logic [31:0] w, input logic u);
        return u ? v + w : v - w;
    endfunction
    function automatic logic [31:0] div(input int d);
        return divider_freq[32*d +: 32];
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 2000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 2000) chk("pready", 1, 0);
    endtask
    task automatic pulse(input logic u);
        @(posedge pclk);
        if (u) step_up_pin <= 1'b1;
        else step_down_pin <= 1'b1;
        @(posedge pclk);
        step_up_pin <= 1'b0;
        step_down_pin <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int n;
        n = 0;
        while (pll_mode !== m && n < lim) begin
            @(posedge pclk);
            n++;
        end
        #1 chk("pll_mode", 32'(m), 32'(pll_mode));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        chk("watchdog", 0, 1);
        stop_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, step_up_pin, step_down_pin, want_valid} = '0;
        hard_reset_pin_n = 1'b1;
        presetn = 1'b0;
        void'($urandom(60235));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk("clocks_enable", 0, clocks_enable);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", NVM_CTRL, rd);
        chk("pll_mode", 32'(MODE_FREE_RUN), 32'(pll_mode));
        chk("clocks_enable", 1, clocks_enable);
        chk("caps", 1, xtal_caps_enable);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 1, err);
        $display("test init done");
        frequency_step_word = $urandom();
        apb(1'b1, OFS_FSW, frequency_step_word);
        apb(1'b1, OFS_CTRL, NVM_CTRL | 32'h80);
        pulse(1'b1);
        chk("div0", NVM_DIV, div(0));
        apb(1'b1, OFS_CTRL, NVM_CTRL | 32'h82);
        d0 = div(0);
        for (int i = 0; i < 6; i++) begin
            up = 1'($urandom_range(1));
            pulse(up);
            d0 = stepped(d0, frequency_step_word, up);
            chk("div0", d0, div(0));
        end
        chk("div3", d0, div(3));
        d1 = div(1);
        apb(1'b1, OFS_STEP, 32'h0000_0202);
        repeat (3) @(posedge pclk);
        d1 = stepped(d1, frequency_step_word, 1'b0);
        chk("div1", d1, div(1));
        chk("div0", d0, div(0));
        $display("test steps done");
        want_valid <= 4'h4;
        wait_mode(MODE_ACQUIRE, 20);
        chk("fastlock", 1, fastlock_active);
        chk("bw", NVM_BW[11:8], loop_bw_code);
        chk("lol", 1, lock_lost_indicator);
        chk("sel", 2, selected_input);
        pulse(1'b1);
        chk("div1", d1, div(1));
        wait_mode(MODE_LOCKED, 100);
        #4 chk("lol", 0, lock_lost_indicator);
        chk("bw", NVM_BW[3:0], loop_bw_code);
        chk("fastlock", 0, fastlock_active);
        pulse(1'b0);
        d1 = stepped(d1, frequency_step_word, 1'b0);
        chk("div1", d1, div(1));
        repeat (60) @(posedge pclk);
        want_valid <= 4'h0;
        wait_mode(MODE_HOLDOVER, 10);
        chk("lol", 1, lock_lost_indicator);
        chk("holdf", 32'h4000_0009, holdover_freq);
        pulse(1'b1);
        chk("div1", d1, div(1));
        want_valid <= 4'h1;
        wait_mode(MODE_ACQUIRE, 10);
        chk("sel", 0, selected_input);
        $display("test modes done");
        @(posedge pclk);
        hard_reset_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        #1 chk("pll_mode", 32'(MODE_INIT), 32'(pll_mode));
        chk("clocks_enable", 0, clocks_enable);
        @(posedge pclk);
        hard_reset_pin_n <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", NVM_CTRL, rd);
        chk("div0", NVM_DIV, div(0));
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        @(posedge pclk);
        #1 chk("pll_mode", 32'(MODE_INIT), 32'(pll_mode));
        $display("test hard reset done");
        stop_test();
    end
endmodule // pll_mode_sequencer_tb_top
